// file: design/tsp_buf2.sv
// Two-entry buffer with valid/ready on both sides.
// Assumes both sides run on the same clock.
`timescale 1ns/1ns
`default_nettype none
module tsp_buf2
    import tsp_pkg::*;
#(
    parameter int WIDTH = BYTE_W
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             reset_n,
    // Filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    logic [WIDTH-1:0] mem_q [2];
    logic [1:0]       cnt_q;
    logic             wr_q;
    logic             rd_q;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_q != BUF_DEPTH);
    assign out_valid = (cnt_q != BUF_EMPTY);
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clock) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= BUF_EMPTY;
            wr_q  <= 1'b0;
            rd_q  <= 1'b0;
        end else begin
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
            if (push) begin
                wr_q <= ~wr_q;
            end
            if (pop) begin
                rd_q <= ~rd_q;
            end
        end
    end
endmodule // tsp_buf2
`default_nettype wire

// file: design/tsp_serial_port.sv
// Bit-level transmit and receive logic of a synchronous TDM serial port.
// Assumes a framer supplies independent, possibly gapped, line clocks.
`timescale 1ns/1ns
`default_nettype none
module tsp_serial_port
    import tsp_pkg::*;
(
    // System clock and reset
    input  wire logic              clock,
    input  wire logic              reset_n,
    // Static configuration
    input  wire logic              x86_mode,
    input  wire logic              tx_enable_active_high,
    input  wire logic              rx_enable_active_high,
    // Core transmit bytes
    input  wire logic              tx_valid,
    output logic                   tx_ready,
    input  wire logic [BYTE_W-1:0] tx_data,
    // Core receive bytes
    output logic                   rx_valid,
    input  wire logic              rx_ready,
    output logic [BYTE_W-1:0]      rx_data,
    output logic                   rx_overrun,
    // Transmit line
    input  wire logic              tx_line_clock_in,
    output logic                   tx_line_data_out,
    input  wire logic              tx_line_data_enable,
    output logic                   tx_byte_boundary_mark,
    output logic                   tx_byte_boundary_mark_oe_n,
    // Receive line
    input  wire logic              rx_line_clock_in,
    input  wire logic              rx_line_data_in,
    input  wire logic              rx_line_data_enable
);
    // ---------------- System side, transmit ----------------
    logic              txb_valid;
    logic              txb_ready;
    logic [BYTE_W-1:0] txb_data;
    logic [BYTE_W-1:0] tx_hold_q;
    logic              tx_req_q;
    logic              tx_ack_s1_q;
    logic              tx_ack_s2_q;
    logic              tx_ack_q;

    tsp_buf2 #(.WIDTH(BYTE_W)) u_tx_buf (
        .clock     (clock),
        .reset_n   (reset_n),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .in_data   (tx_data),
        .out_valid (txb_valid),
        .out_ready (txb_ready),
        .out_data  (txb_data)
    );

    // Holding register is free once the link side has acknowledged
    assign txb_ready = (tx_req_q == tx_ack_s2_q);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            tx_req_q    <= 1'b0;
            tx_hold_q   <= TX_IDLE_FILL;
            tx_ack_s1_q <= 1'b0;
            tx_ack_s2_q <= 1'b0;
        end else begin
            tx_ack_s1_q <= tx_ack_q;
            tx_ack_s2_q <= tx_ack_s1_q;
            if (txb_valid && txb_ready) begin
                tx_hold_q <= txb_data;
                tx_req_q  <= ~tx_req_q;
            end
        end
    end

    // ---------------- Transmit line domain ----------------
    logic [1:0]        tx_rst_q;
    logic              tx_rst_n;
    logic              tx_req_s1_q;
    logic              tx_req_s2_q;
    logic              tx_x86_s1_q;
    logic              tx_x86_q;
    logic              tx_pol_s1_q;
    logic              tx_pol_q;
    logic [2:0]        tx_cnt_q;
    logic [BYTE_W-1:0] tx_sh_q;
    logic              tx_out_q;
    logic              tx_mark_q;
    logic              tx_adv;
    logic              tx_pending;
    logic [BYTE_W-1:0] tx_next_byte;

    always_ff @(posedge tx_line_clock_in or negedge reset_n) begin
        if (!reset_n) begin
            tx_rst_q <= RST_SYNC_INIT;
        end else begin
            tx_rst_q <= {tx_rst_q[0], 1'b1};
        end
    end
    assign tx_rst_n = tx_rst_q[1];

    always_ff @(posedge tx_line_clock_in or negedge tx_rst_n) begin
        if (!tx_rst_n) begin
            tx_req_s1_q <= 1'b0;
            tx_req_s2_q <= 1'b0;
            tx_x86_s1_q <= 1'b0;
            tx_x86_q    <= 1'b0;
            tx_pol_s1_q <= 1'b0;
            tx_pol_q    <= 1'b0;
        end else begin
            tx_req_s1_q <= tx_req_q;
            tx_req_s2_q <= tx_req_s1_q;
            tx_x86_s1_q <= x86_mode;
            tx_x86_q    <= tx_x86_s1_q;
            tx_pol_s1_q <= tx_enable_active_high;
            tx_pol_q    <= tx_pol_s1_q;
        end
    end

    // Enable sampled at this edge governs the bit launched at this edge
    assign tx_adv       = tx_x86_q || (tx_line_data_enable == tx_pol_q);
    assign tx_pending   = (tx_req_s2_q != tx_ack_q);
    assign tx_next_byte = tx_pending ? tx_hold_q : TX_IDLE_FILL;

    always_ff @(posedge tx_line_clock_in or negedge tx_rst_n) begin
        if (!tx_rst_n) begin
            tx_cnt_q  <= FIRST_BIT;
            tx_sh_q   <= TX_IDLE_FILL;
            tx_out_q  <= 1'b1;
            tx_ack_q  <= 1'b0;
            tx_mark_q <= 1'b0;
        end else begin
            tx_mark_q <= tx_adv && tx_x86_q && (tx_cnt_q == LAST_BIT);
            if (tx_adv) begin
                tx_cnt_q <= tx_cnt_q + 3'h1;
                if (tx_cnt_q == FIRST_BIT) begin
                    tx_out_q <= tx_next_byte[0];
                    tx_sh_q  <= {1'b0, tx_next_byte[BYTE_W-1:1]};
                    if (tx_pending) begin
                        tx_ack_q <= ~tx_ack_q;
                    end
                end else begin
                    tx_out_q <= tx_sh_q[0];
                    tx_sh_q  <= {1'b0, tx_sh_q[BYTE_W-1:1]};
                end
            end
        end
    end

    assign tx_line_data_out           = tx_out_q;
    assign tx_byte_boundary_mark      = tx_mark_q;
    assign tx_byte_boundary_mark_oe_n = ~tx_x86_q;

    // ---------------- Receive line domain ----------------
    logic [1:0]        rx_rst_q;
    logic              rx_rst_n;
    logic              rx_x86_s1_q;
    logic              rx_x86_q;
    logic              rx_pol_s1_q;
    logic              rx_pol_q;
    logic [1:0]        rx_cfg_q;
    logic [2:0]        rx_cnt_q;
    logic [BYTE_W-1:0] rx_sh_q;
    logic [BYTE_W-1:0] rx_word_q;
    logic              rx_tog_q;
    logic              rx_take;
    logic              rx_first;
    logic [2:0]        rx_idx;

    always_ff @(posedge rx_line_clock_in or negedge reset_n) begin
        if (!reset_n) begin
            rx_rst_q <= RST_SYNC_INIT;
        end else begin
            rx_rst_q <= {rx_rst_q[0], 1'b1};
        end
    end
    assign rx_rst_n = rx_rst_q[1];
    always_ff @(posedge rx_line_clock_in or negedge rx_rst_n) begin
        if (!rx_rst_n) begin
            rx_x86_s1_q <= 1'b0;
            rx_x86_q    <= 1'b0;
            rx_pol_s1_q <= 1'b0;
            rx_pol_q    <= 1'b0;
            rx_cfg_q    <= RST_SYNC_INIT;
        end else begin
            rx_cfg_q    <= {rx_cfg_q[0], 1'b1};
            rx_x86_s1_q <= x86_mode;
            rx_x86_q    <= rx_x86_s1_q;
            rx_pol_s1_q <= rx_enable_active_high;
            rx_pol_q    <= rx_pol_s1_q;
        end
    end

    // Shared pin: data enable in HDLC, byte boundary mark in X.86
    assign rx_take  = rx_cfg_q[1] && (rx_x86_q || (rx_line_data_enable == rx_pol_q));
    assign rx_first = rx_cfg_q[1] && rx_x86_q && rx_line_data_enable;
    assign rx_idx   = rx_first ? FIRST_BIT : rx_cnt_q;

    always_ff @(posedge rx_line_clock_in or negedge rx_rst_n) begin
        if (!rx_rst_n) begin
            rx_cnt_q  <= FIRST_BIT;
            rx_sh_q   <= '0;
            rx_word_q <= '0;
            rx_tog_q  <= 1'b0;
        end else if (rx_take) begin
            rx_sh_q  <= {rx_line_data_in, rx_sh_q[BYTE_W-1:1]};
            rx_cnt_q <= rx_idx + 3'h1;
            if (rx_idx == LAST_BIT) begin
                rx_word_q <= {rx_line_data_in, rx_sh_q[BYTE_W-1:1]};
                rx_tog_q  <= ~rx_tog_q;
            end
        end
    end

    // ---------------- System side, receive ----------------
    logic              rx_tog_s1_q;
    logic              rx_tog_s2_q;
    logic              rx_tog_s3_q;
    logic              rx_new;
    logic              rxb_ready;
    logic              rx_overrun_q;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rx_tog_s1_q  <= 1'b0;
            rx_tog_s2_q  <= 1'b0;
            rx_tog_s3_q  <= 1'b0;
            rx_overrun_q <= 1'b0;
        end else begin
            rx_tog_s1_q <= rx_tog_q;
            rx_tog_s2_q <= rx_tog_s1_q;
            rx_tog_s3_q <= rx_tog_s2_q;
            if (rx_new && !rxb_ready) begin
                rx_overrun_q <= 1'b1;
            end
        end
    end
    // Word stays stable for eight line bits after the toggle
    assign rx_new     = rx_tog_s2_q ^ rx_tog_s3_q;
    assign rx_overrun = rx_overrun_q;

    tsp_buf2 #(.WIDTH(BYTE_W)) u_rx_buf (
        .clock     (clock),
        .reset_n   (reset_n),
        .in_valid  (rx_new),
        .in_ready  (rxb_ready),
        .in_data   (rx_word_q),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (rx_data)
    );

    // ---------------- Checks ----------------
    tx_skip_hold_a: assert property (@(posedge tx_line_clock_in) disable iff (!tx_rst_n)
        !tx_adv |=> $stable(tx_out_q) && $stable(tx_cnt_q))
        else $error("transmit output moved on a skipped period");

    tx_polarity_a: assert property (@(posedge tx_line_clock_in) disable iff (!tx_rst_n)
        (!tx_x86_q && tx_line_data_enable == tx_pol_q) |=> tx_cnt_q == $past(tx_cnt_q) + 3'h1)
        else $error("active transmit enable did not advance a bit");

    tx_launch_a: assert property (@(posedge tx_line_clock_in) disable iff (!tx_rst_n)
        (tx_adv && tx_cnt_q != FIRST_BIT) |=> tx_out_q == $past(tx_sh_q[0]))
        else $error("transmit bit not launched from shifter");

    tx_mark_last_a: assert property (@(posedge tx_line_clock_in) disable iff (!tx_rst_n)
        tx_mark_q |-> $past(tx_cnt_q) == LAST_BIT && $past(tx_adv) && tx_cnt_q == FIRST_BIT)
        else $error("byte mark not on last bit");

    tx_pin_dir_a: assert property (@(posedge tx_line_clock_in) disable iff (!tx_rst_n)
        !tx_x86_q |-> tx_byte_boundary_mark_oe_n && !tx_mark_q)
        else $error("shared transmit pin driven outside X.86 mode");

    rx_capture_a: assert property (@(posedge rx_line_clock_in) disable iff (!rx_rst_n)
        rx_take |=> rx_sh_q[BYTE_W-1] == $past(rx_line_data_in))
        else $error("receive bit not captured on its edge");

    rx_sync_a: assert property (@(posedge rx_line_clock_in) disable iff (!rx_rst_n)
        (rx_first ##1 rx_take [*7]) |=> $changed(rx_tog_q))
        else $error("receive byte not completed after boundary mark");

    tx_handshake_a: assert property (@(posedge clock) disable iff (!reset_n)
        $changed(tx_req_q) |-> $past(tx_req_q == tx_ack_s2_q) ##1 !txb_ready)
        else $error("transmit word sent before acknowledge");
endmodule // tsp_serial_port
`default_nettype wire

// file: shared/tsp_pkg.sv
// Shared constants for the TDM serial port pin logic.
// Assumes nothing beyond a SystemVerilog compiler.
package tsp_pkg;
    localparam int          BYTE_W       = 8;
    localparam logic [2:0]  FIRST_BIT    = 3'h0;
    localparam logic [2:0]  SECOND_BIT   = 3'h1;
    localparam logic [2:0]  LAST_BIT     = 3'h7;
    localparam logic [7:0]  TX_IDLE_FILL = 8'h7E;
    localparam logic [1:0]  RST_SYNC_INIT = 2'h0;
    localparam logic [1:0]  BUF_DEPTH    = 2'h2;
    localparam logic [1:0]  BUF_EMPTY    = 2'h0;
endpackage

// file: tb/tb_tsp_serial_port.sv
// Self-checking bench for the TDM serial port pin logic.
// Assumes the package and the far-end model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_tsp_serial_port
    import tsp_pkg::*;
    ;
    logic        clock, reset_n, x86_mode, tx_pol, rx_pol, full_seen;
    logic        tx_valid, tx_ready, rx_valid, rx_ready, rx_overrun;
    logic [7:0]  tx_data, rx_data;
    logic        t_clk, t_dat, t_mark, t_oe_n, far_en, pin, r_clk, r_dat, r_en;
    logic [31:0] seed = 32'h42EB;
    int          failures = 0;
    int          tests_run = 0;
    int          cycles = 0;
    logic [7:0]  txq[$], rxq[$];
    logic [2:0]  cfgs[4] = '{3'h7, 3'h4, 3'h2, 3'h1};

    // Shared enable/mark pin
    assign pin = t_oe_n ? far_en : t_mark;

    tsp_serial_port i_dut (.clock(clock), .reset_n(reset_n), .x86_mode(x86_mode),
        .tx_enable_active_high(tx_pol), .rx_enable_active_high(rx_pol),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
        .rx_overrun(rx_overrun), .tx_line_clock_in(t_clk), .tx_line_data_out(t_dat),
        .tx_line_data_enable(pin), .tx_byte_boundary_mark(t_mark),
        .tx_byte_boundary_mark_oe_n(t_oe_n), .rx_line_clock_in(r_clk),
        .rx_line_data_in(r_dat), .rx_line_data_enable(r_en));

    tsp_far_end i_far (.x86_mode(x86_mode), .tx_pol(tx_pol), .rx_pol(rx_pol),
        .tx_clk(t_clk), .tx_dat(t_dat), .tx_en(far_en), .tx_pin(pin), .tx_oe_n(t_oe_n),
        .rx_clk(r_clk), .rx_dat(r_dat), .rx_en(r_en));

    initial begin
        clock = 1'h0;
        forever #5 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles++;
        if (!tx_ready) full_seen = 1'h1;
        if (cycles == 60000) begin
            failures++;
            wrap_up();
        end
    end

    function automatic logic [7:0] fresh();
        logic [7:0] b;
        b = 8'($random(seed));
        return (b == TX_IDLE_FILL) ? 8'h00 : b;
    endfunction

    // Bytes the receive buffer can keep with the core stalled
    function automatic int kept(input int sent);
        return (sent < int'(BUF_DEPTH)) ? sent : int'(BUF_DEPTH);
    endfunction

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("failures=%0d tests_run=%0d", failures, tests_run);
        if (failures == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic phase(input logic [2:0] cfg, input int n, input logic hold);
        int   k;
        logic rx_done;
        @(negedge clock);
        {x86_mode, tx_pol, rx_pol} = cfg;
        reset_n = 1'h0;
        tx_valid = 1'h0;
        rx_ready = 1'h0;
        i_far.armed = 1'h0;
        i_far.got.delete();
        i_far.nb = -1;
        i_far.tie = (cfg == 3'h2);
        txq.delete();
        rxq.delete();
        rx_done = 1'h0;
        fork
            i_far.warm(4);
            repeat (4) @(negedge clock);
        join
        @(negedge clock);
        reset_n = 1'h1;
        i_far.warm(4);
        repeat (20) @(negedge clock);
        i_far.armed = 1'h1;
        full_seen = 1'h0;
        fork
            begin
                for (int i = 0; i < n; i++) begin
                    @(negedge clock);
                    tx_data = fresh();
                    tx_valid = 1'h1;
                    @(posedge clock);
                    while (!tx_ready) @(posedge clock);
                    txq.push_back(tx_data);
                end
                @(negedge clock) tx_valid = 1'h0;
            end
            begin
                for (int i = 0; i < n; i++) begin
                    rxq.push_back(fresh());
                    i_far.send(rxq[i]);
                end
                rx_done = 1'h1;
            end
            begin
                if (hold) wait (rx_done);
                if (hold) repeat (20) @(negedge clock);
                k = 0;
                while (k < (hold ? kept(n) : n)) begin
                    @(negedge clock);
                    rx_ready = hold ? 1'h1 : 1'($random(seed));
                    @(posedge clock);
                    if (rx_valid === 1'h1 && rx_ready) begin
                        check(rx_data, rxq[k], "rx byte");
                        k++;
                    end
                end
            end
        join
        repeat (8) @(negedge clock);
        check({7'h0, rx_valid}, 8'h00, "rx extra");
        check({7'h0, rx_overrun}, {7'h0, hold}, "rx overrun");
        check({7'h0, full_seen}, 8'h01, "tx stall");
        if (x86_mode) begin
            k = 0;
            for (int c = 0; c < 4000 && i_far.got.size() < n + 40; c++) @(negedge clock);
            foreach (i_far.got[i])
                if (i_far.got[i] != TX_IDLE_FILL && k < n) begin
                    check(i_far.got[i], txq[k], "tx byte");
                    k++;
                end
            check(8'(k), 8'(n), "tx count");
        end
        check({7'h0, i_far.moves > 0}, 8'h01, "tx moves");
        check({7'h0, i_far.bad != 0}, 8'h00, "line rules");
    endtask

    initial begin
        reset_n = 1'h0;
        x86_mode = 1'h0;
        tx_pol = 1'h1;
        rx_pol = 1'h1;
        tx_valid = 1'h0;
        tx_data = 8'h00;
        rx_ready = 1'h0;
        full_seen = 1'h0;
        foreach (cfgs[i]) phase(cfgs[i], 16, 1'h0);
        phase(3'h4, 3, 1'h1);
        wrap_up();
    end
endmodule // tb_tsp_serial_port
`default_nettype wire

// file: tb/tsp_far_end.sv
// Far-end framer model: gapped line clocks, enable and byte marks.
// Assumes the bench resolves the shared enable/mark pin.
`timescale 1ns/1ns
`default_nettype none
module tsp_far_end
    import tsp_pkg::*;
(
    // Configuration mirror
    input  wire logic x86_mode,
    input  wire logic tx_pol,
    input  wire logic rx_pol,
    // Transmit line
    output logic      tx_clk,
    input  wire logic tx_dat,
    output logic      tx_en,
    input  wire logic tx_pin,
    input  wire logic tx_oe_n,
    // Receive line
    output logic      rx_clk,
    output logic      rx_dat,
    output logic      rx_en
);
    logic [31:0] seed = 32'h42EB;
    logic        run = 1'h1;
    logic        armed = 1'h0;
    logic        tie = 1'h0;
    logic        adv;
    logic        was;
    logic [7:0]  sh;
    int          nb = -1;
    int          bad = 0;
    int          moves = 0;
    logic [7:0]  got[$];

    // Gapped transmit clock, 12 ns when running
    initial begin
        tx_clk = 1'h0;
        tx_en = 1'h0;
        rx_clk = 1'h0;
        rx_dat = 1'h0;
        rx_en = 1'h0;
        forever begin
            #6;
            if (tx_clk) tx_clk = 1'h0;
            else if (run && ($random(seed) & 3) != 0) tx_clk = 1'h1;
        end
    end

    always @(negedge tx_clk) tx_en <= tie ? 1'h1 : 1'($random(seed));

    always @(posedge tx_clk) begin
        adv = x86_mode || (tx_pin == tx_pol);
        was = tx_dat;
    end

    always @(negedge tx_clk) if (armed) begin
        if (!adv && tx_dat !== was) bad++;
        if (!x86_mode && tx_oe_n !== 1'h1) bad++;
        if (adv && tx_dat !== was) moves++;
        if (adv && x86_mode) begin
            sh = {tx_dat, sh[7:1]};
            if (tx_pin) begin
                if (nb >= 0 && nb != 7) bad++;
                if (nb >= 0) got.push_back(sh);
                nb = 0;
            end else if (nb >= 0) nb++;
        end
    end

    task automatic rx_bit(input logic d, input logic q, input logic m);
        rx_dat = d;
        rx_en = x86_mode ? m : (q ~^ rx_pol);
        #6 rx_clk = 1'h1;
        #6 rx_clk = 1'h0;
    endtask

    task automatic warm(input int n);
        repeat (n) rx_bit(1'($random(seed)), 1'h0, 1'h0);
    endtask

    task automatic send(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            while (!x86_mode && ($random(seed) & 3) == 0) rx_bit(~b[i], 1'h0, 1'h0);
            rx_bit(b[i], 1'h1, i == 0);
        end
        rx_dat = ~b[7];
    endtask
endmodule // tsp_far_end
`default_nettype wire
